// file: include/swf_pkg.sv
// Shared constants and decode functions for the single-wire flash link.
package swf_pkg;
  // Timing of the pin and of the flash safety timer.
  localparam int CLK_HZ = 50_000_000;
  localparam int EN_TIME_US = 1000;
  localparam int DIS_TIME_US = 10000;
  localparam int TIMEOUT_MS = 1000;
  localparam int EN_CYC = EN_TIME_US * (CLK_HZ / 1_000_000);
  localparam int DIS_CYC = DIS_TIME_US * (CLK_HZ / 1_000_000);
  localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);

  // Frame layout.
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int FRAME_W = ADDR_W + DATA_W;
  localparam int STANDBY_BITS = 5;
  localparam logic [4:0] PREAMBLE = 5'h0A;
  localparam logic [4:0] STANDBY_PAT = 5'h1F;

  // Device register bank.
  localparam logic [4:0] ADDR_FLASH = 5'h02;
  localparam logic [4:0] ADDR_REGUL = 5'h03;
  localparam logic [7:0] FLASH_RST = 8'h10;
  localparam logic [7:0] REGUL_RST = 8'h00;
  localparam int RANGE_BIT = 0;
  localparam int CODE_LSB = 1;
  localparam int TO_BIT = 4;
  localparam int RA_LSB = 0;
  localparam int RB_LSB = 4;

  // Output decode steps.
  localparam logic [9:0] STEP_MA = 10'h032;
  localparam logic [9:0] SPOT_MAX_MA = 10'h0FA;
  localparam logic [9:0] FLASH_MAX_MA = 10'h190;
  localparam logic [11:0] STEP_MV = 12'h064;
  localparam logic [11:0] RA_TOP_MV = 12'hD48;
  localparam logic [11:0] RB_TOP_MV = 12'h76C;
  localparam logic [3:0] RA_CODES = 4'h9;
  localparam logic [2:0] RB_CODES = 3'h4;

  // Host register map on APB.
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] FRAME_OFS = 12'h004;
  localparam logic [11:0] STATUS_OFS = 12'h008;
  localparam int CTRL_POWER_BIT = 0;
  localparam int CTRL_RATE_LSB = 16;
  localparam logic [15:0] RATE_RST = 16'h0064;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_READY_BIT = 1;
  localparam int ST_PEND_BIT = 2;

  function automatic logic [9:0] sink_ma(input logic rng,
                                         input logic [2:0] code);
    logic [9:0] v;
    v = STEP_MA * 10'(code);
    if (code == 3'h0) return 10'h000;
    if (rng) begin
      v = SPOT_MAX_MA + v;
      return (v > FLASH_MAX_MA) ? FLASH_MAX_MA : v;
    end
    return (v > SPOT_MAX_MA) ? SPOT_MAX_MA : v;
  endfunction : sink_ma

  function automatic logic [11:0] reg_a_mv(input logic [3:0] code);
    if (code == 4'h0 || code > RA_CODES) return 12'h000;
    return RA_TOP_MV - STEP_MV * 12'(code);
  endfunction : reg_a_mv

  function automatic logic [11:0] reg_b_mv(input logic [2:0] code);
    if (code == 3'h0 || code > RB_CODES) return 12'h000;
    return RB_TOP_MV - STEP_MV * 12'(code);
  endfunction : reg_b_mv
endpackage : swf_pkg

// file: include/swf_link_if.sv
// Single serial wire between host and device, open drain with pull-up.
`timescale 1ns/1ps
interface swf_link_if;
  logic pin_o;
  logic pin_oe_n;
  logic line;

  // The pull-up holds the wire high whenever the host releases it.
  assign line = pin_oe_n ? 1'b1 : pin_o;

  modport host(output pin_o, output pin_oe_n, input line);
  modport device(input line);
endinterface : swf_link_if

// file: design/swf_device.sv
// Device end: frame receiver, register bank, sleep and timeout control.
//
// Operation
// - Range bit set selects flash current range.
// - Range bit clear selects continuous spotlight range.
// - Regulator B code decodes 1.8V to 1.5V.
// - Regulator A code decodes 3.3V to 2.5V.
// - Write-only pin, five-bit address space.
// - High over 1ms enables into sleep.
// - Sleep state keeps watching the pin.
// - Sink off means sleep, regulators stay.
// - Low over 10ms shuts down until re-enabled.
// - Shutdown clears registers, timeout enable set.
// - Low then high bit wakes oscillator.
// - Second low-high pair measures bit rate.
// - One low bit marks frame start.
// - Five address bits follow, MSB first.
// - Eight data bits follow, then written.
// - Five high bits return to standby.
// - Host chains writes after last bit.
// - Host keeps bit rate within limits.
// - Timeout cuts flash after one second.
// - Current code selects 50mA steps.
// - Host writes zero to unused bits; this host clears data bit 7 only.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module swf_device #(
  parameter int EN_CYC = swf_pkg::EN_CYC,
  parameter int DIS_CYC = swf_pkg::DIS_CYC,
  parameter int TIMEOUT_CYC = swf_pkg::TIMEOUT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  swf_link_if.device link,
  input wire logic strobe_enable_pin,
  output logic enabled,
  output logic awake,
  output logic range_select,
  output logic flash_timeout_enable,
  output logic [2:0] sink_current_code,
  output logic sink_on,
  output logic timed_out,
  output logic [9:0] sink_ma,
  output logic [3:0] regulator_a_voltage,
  output logic [2:0] regulator_b_voltage,
  output logic [11:0] reg_a_mv,
  output logic [11:0] reg_b_mv
);
  typedef enum logic [2:0] {
    ST_OFF, ST_IDLE, ST_WAKE_LO, ST_WAKE_HI, ST_RATE, ST_BITS, ST_TAIL,
    ST_GAP
  } state_t;

  state_t st_q;
  logic prev_q;
  logic [31:0] low_cnt_q;
  logic [31:0] high_cnt_q;
  logic [19:0] meas_q;
  logic seen_hi_q;
  logic [15:0] bit_len_q;
  logic [19:0] cnt_q;
  logic [3:0] nbit_q;
  logic [11:0] sh_q;
  logic [7:0] flash_q;
  logic [7:0] regul_q;
  logic [31:0] to_cnt_q;
  logic to_q;
  logic fall;
  logic rise;
  logic shut;
  logic en_long;
  logic commit;
  logic [12:0] frame;
  logic [15:0] bit_len_d;
  logic code_nz;
  logic active;

  assign fall = prev_q & ~link.line;
  assign rise = ~prev_q & link.line;
  assign shut = low_cnt_q >= 32'(DIS_CYC);
  assign en_long = high_cnt_q >= 32'(EN_CYC);
  assign frame = {sh_q, link.line};
  assign commit = (st_q == ST_BITS) && (cnt_q == 20'h00001) &&
                  (nbit_q == 4'(swf_pkg::FRAME_W - 1));
  // Fall to fall of the rate pair is exactly two bits; any extra cycle here
  // would build up over the 13 frame bits and push samples off centre.
  assign bit_len_d = meas_q[16:1];
  assign code_nz = flash_q[swf_pkg::CODE_LSB +: 3] != 3'h0;
  assign active = code_nz && !to_q && (st_q != ST_OFF);

  // Level lengths on the pin drive enable and shutdown.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
      low_cnt_q <= 32'h00000000;
      high_cnt_q <= 32'h00000000;
    end else begin
      prev_q <= link.line;
      if (link.line) begin
        low_cnt_q <= 32'h00000000;
        if (!en_long) begin
          high_cnt_q <= high_cnt_q + 32'h00000001;
        end
      end else begin
        high_cnt_q <= 32'h00000000;
        if (!shut) begin
          low_cnt_q <= low_cnt_q + 32'h00000001;
        end
      end
    end
  end

  // Frame receiver.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_OFF;
      meas_q <= 20'h00000;
      seen_hi_q <= 1'b0;
      bit_len_q <= 16'h0000;
      cnt_q <= 20'h00000;
      nbit_q <= 4'h0;
      sh_q <= 12'h000;
    end else if (shut) begin
      st_q <= ST_OFF;
    end else begin
      unique case (st_q)
        ST_OFF: begin
          if (en_long) begin
            st_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (fall) begin
            st_q <= ST_WAKE_LO;
          end
        end
        ST_WAKE_LO: begin
          if (rise) begin
            st_q <= ST_WAKE_HI;
          end
        end
        ST_WAKE_HI: begin
          if (fall) begin
            st_q <= ST_RATE;
            meas_q <= 20'h00001;
            seen_hi_q <= 1'b0;
          end
        end
        ST_RATE: begin
          meas_q <= meas_q + 20'h00001;
          if (rise) begin
            seen_hi_q <= 1'b1;
          end
          if (fall && seen_hi_q) begin
            // Fall to fall spans two bits; the start bit begins now.
            bit_len_q <= bit_len_d;
            cnt_q <= 20'(bit_len_d) + 20'(bit_len_d[15:1]);
            nbit_q <= 4'h0;
            st_q <= ST_BITS;
          end
        end
        ST_BITS: begin
          if (cnt_q == 20'h00001) begin
            // Sample each bit at its centre, MSB first.
            sh_q <= frame[11:0];
            nbit_q <= nbit_q + 4'h1;
            cnt_q <= 20'(bit_len_q);
            if (commit) begin
              cnt_q <= 20'(bit_len_q[15:1]) + 20'h00001;
              st_q <= ST_TAIL;
            end
          end else begin
            cnt_q <= cnt_q - 20'h00001;
          end
        end
        ST_TAIL: begin
          if (cnt_q == 20'h00001) begin
            cnt_q <= 20'h00000;
            st_q <= ST_GAP;
          end else begin
            cnt_q <= cnt_q - 20'h00001;
          end
        end
        ST_GAP: begin
          cnt_q <= cnt_q + 20'h00001;
          if (!link.line) begin
            st_q <= ST_WAKE_LO;
          end else if (cnt_q >=
                       20'(swf_pkg::STANDBY_BITS) * 20'(bit_len_q)) begin
            st_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Register bank, written only by a complete frame.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_q <= swf_pkg::FLASH_RST;
      regul_q <= swf_pkg::REGUL_RST;
    end else if (shut) begin
      flash_q <= swf_pkg::FLASH_RST;
      regul_q <= swf_pkg::REGUL_RST;
    end else if (commit) begin
      // Any other address of the 32 leaves the bank alone.
      if (frame[12:8] == swf_pkg::ADDR_FLASH) begin
        flash_q <= frame[7:0];
      end else if (frame[12:8] == swf_pkg::ADDR_REGUL) begin
        regul_q <= frame[7:0];
      end
    end
  end

  // Flash safety timer; strobe low or a cleared code re-arms it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_cnt_q <= 32'h00000000;
      to_q <= 1'b0;
    end else if (shut || !strobe_enable_pin || !code_nz) begin
      to_cnt_q <= 32'h00000000;
      to_q <= 1'b0;
    end else if (active && flash_q[swf_pkg::TO_BIT]) begin
      if (to_cnt_q >= 32'(TIMEOUT_CYC - 1)) begin
        to_q <= 1'b1;
      end else begin
        to_cnt_q <= to_cnt_q + 32'h00000001;
      end
    end
  end

  // Registered outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enabled <= 1'b0;
      awake <= 1'b0;
      range_select <= 1'b0;
      flash_timeout_enable <= 1'b0;
      sink_current_code <= 3'h0;
      sink_on <= 1'b0;
      timed_out <= 1'b0;
      sink_ma <= 10'h000;
      regulator_a_voltage <= 4'h0;
      regulator_b_voltage <= 3'h0;
      reg_a_mv <= 12'h000;
      reg_b_mv <= 12'h000;
    end else begin
      enabled <= st_q != ST_OFF;
      // Oscillator and pump run only while a frame or the sink is active.
      awake <= active || (st_q != ST_OFF && st_q != ST_IDLE);
      range_select <= flash_q[swf_pkg::RANGE_BIT];
      flash_timeout_enable <= flash_q[swf_pkg::TO_BIT];
      sink_current_code <= flash_q[swf_pkg::CODE_LSB +: 3];
      sink_on <= active;
      timed_out <= to_q;
      sink_ma <= active ? swf_pkg::sink_ma(flash_q[swf_pkg::RANGE_BIT],
        flash_q[swf_pkg::CODE_LSB +: 3]) : 10'h000;
      regulator_a_voltage <= regul_q[swf_pkg::RA_LSB +: 4];
      regulator_b_voltage <= regul_q[swf_pkg::RB_LSB +: 3];
      reg_a_mv <= swf_pkg::reg_a_mv(regul_q[swf_pkg::RA_LSB +: 4]);
      reg_b_mv <= swf_pkg::reg_b_mv(regul_q[swf_pkg::RB_LSB +: 3]);
    end
  end
endmodule : swf_device

// file: design/swf_host.sv
// Host end: APB-controlled driver of the single serial wire.
`timescale 1ns/1ps
module swf_host #(
  parameter int EN_CYC = swf_pkg::EN_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  swf_link_if.host link
);
  localparam int SYM_W = 10 + swf_pkg::FRAME_W;
  localparam logic [4:0] LAST_DATA = 5'(5 + swf_pkg::FRAME_W - 1);
  localparam logic [4:0] LAST_SYM = 5'(SYM_W - 1);

  logic power_q;
  logic [15:0] rate_q;
  logic ready_q;
  logic [31:0] hcnt_q;
  logic busy_q;
  logic [SYM_W-1:0] sh_q;
  logic [4:0] sym_q;
  logic [15:0] bcnt_q;
  logic pend_q;
  logic [12:0] pend_word_q;
  logic acc;
  logic fr_wr;
  logic fr_ok;
  logic mapped;

  assign acc = psel & penable;
  assign mapped = paddr == swf_pkg::CTRL_OFS || paddr == swf_pkg::FRAME_OFS ||
                  paddr == swf_pkg::STATUS_OFS;
  assign fr_wr = acc && pwrite && paddr == swf_pkg::FRAME_OFS;
  assign fr_ok = ready_q && !pend_q;
  assign pready = 1'b1;
  assign pslverr = acc && (!mapped || (fr_wr && !fr_ok));
  // Open drain: released wire is pulled high by the pull-up.
  assign link.pin_o = 1'b0;
  assign link.pin_oe_n = busy_q ? sh_q[SYM_W-1] : power_q;

  always_comb begin
    prdata = 32'h00000000;
    if (paddr == swf_pkg::CTRL_OFS) begin
      prdata[swf_pkg::CTRL_POWER_BIT] = power_q;
      prdata[swf_pkg::CTRL_RATE_LSB +: 16] = rate_q;
    end else if (paddr == swf_pkg::FRAME_OFS) begin
      prdata[12:0] = pend_word_q;
    end else if (paddr == swf_pkg::STATUS_OFS) begin
      prdata[swf_pkg::ST_BUSY_BIT] = busy_q;
      prdata[swf_pkg::ST_READY_BIT] = ready_q;
      prdata[swf_pkg::ST_PEND_BIT] = pend_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_q <= 1'b0;
      rate_q <= swf_pkg::RATE_RST;
    end else if (acc && pwrite && paddr == swf_pkg::CTRL_OFS) begin
      power_q <= pwdata[swf_pkg::CTRL_POWER_BIT];
      rate_q <= pwdata[swf_pkg::CTRL_RATE_LSB +: 16];
    end
  end

  // Frames are sent only once the wire has been high long enough.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcnt_q <= 32'h00000000;
      ready_q <= 1'b0;
    end else if (!power_q) begin
      hcnt_q <= 32'h00000000;
      ready_q <= 1'b0;
    end else if (hcnt_q >= 32'(EN_CYC)) begin
      ready_q <= 1'b1;
    end else begin
      hcnt_q <= hcnt_q + 32'h00000001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      sh_q <= '0;
      sym_q <= 5'h00;
      bcnt_q <= 16'h0000;
      pend_q <= 1'b0;
      pend_word_q <= 13'h0000;
    end else begin
      if (fr_wr && fr_ok) begin
        pend_q <= 1'b1;
        pend_word_q <= pwdata[12:0] & 13'h1F7F;
      end
      if (!power_q) begin
        busy_q <= 1'b0;
        pend_q <= 1'b0;
      end else if (!busy_q && pend_q) begin
        busy_q <= 1'b1;
        sh_q <= {swf_pkg::PREAMBLE, pend_word_q, swf_pkg::STANDBY_PAT};
        sym_q <= 5'h00;
        bcnt_q <= rate_q;
        pend_q <= 1'b0;
      end else if (busy_q) begin
        if (bcnt_q <= 16'h0001) begin
          bcnt_q <= rate_q;
          sym_q <= sym_q + 5'h01;
          sh_q <= {sh_q[SYM_W-2:0], 1'b1};
          if (sym_q == LAST_DATA && pend_q) begin
            sh_q <= {swf_pkg::PREAMBLE, pend_word_q, swf_pkg::STANDBY_PAT};
            sym_q <= 5'h00;
            pend_q <= 1'b0;
          end else if (sym_q == LAST_SYM) begin
            busy_q <= 1'b0;
          end
        end else begin
          bcnt_q <= bcnt_q - 16'h0001;
        end
      end
    end
  end
endmodule : swf_host

// file: bench/swf_asserts.sv
// Checker of the wire timing and of the device decode outputs.
`timescale 1ns/1ps
module swf_asserts #(
  parameter int EN_CYC = 200,
  parameter int DIS_CYC = 2000,
  parameter int QUIET = 500
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic line,
  input wire logic enabled,
  input wire logic awake,
  input wire logic range_select,
  input wire logic flash_timeout_enable,
  input wire logic [2:0] sink_current_code,
  input wire logic sink_on,
  input wire logic timed_out,
  input wire logic [9:0] sink_ma,
  input wire logic [3:0] regulator_a_voltage,
  input wire logic [2:0] regulator_b_voltage,
  input wire logic [11:0] reg_a_mv,
  input wire logic [11:0] reg_b_mv
);
  int hi_q;
  int lo_q;

  // Lengths of the current high and low stretches of the wire.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_q <= 0;
      lo_q <= 0;
    end else begin
      hi_q <= line ? hi_q + 1 : 0;
      lo_q <= line ? 0 : lo_q + 1;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_quiet;
    (!sink_on && hi_q > QUIET) [*2];
  endsequence

  AST_EN_LATE: assert property (hi_q > EN_CYC + 4 |-> enabled)
    else $error("device not enabled after long high");
  AST_EN_EARLY: assert property ($rose(enabled) |-> hi_q >= EN_CYC - 3)
    else $error("device enabled too early");
  AST_DIS_LATE: assert property (lo_q > DIS_CYC + 4 |-> !enabled)
    else $error("device not shut down after long low");
  AST_DIS_EARLY: assert property ($fell(enabled) |-> lo_q >= DIS_CYC - 3)
    else $error("device shut down too early");
  AST_SHUT_RST: assert property (lo_q > DIS_CYC + 8 |->
    flash_timeout_enable && !range_select && sink_current_code == 3'h0 &&
    regulator_a_voltage == 4'h0 && regulator_b_voltage == 3'h0)
    else $error("registers not at defaults after shutdown");
  AST_SLEEP: assert property (s_quiet |-> !awake)
    else $error("device awake while idle with sink off");
  AST_SPOT: assert property ((sink_on && !range_select &&
    $stable(sink_current_code)) [*3] |-> sink_ma ==
    ((sink_current_code > 3'h5) ? 10'h0FA : 10'h032 * sink_current_code))
    else $error("spotlight current decode wrong");
  AST_FLASH: assert property ((sink_on && range_select &&
    $stable(sink_current_code)) [*3] |-> sink_ma == ((sink_current_code >
    3'h3) ? 10'h190 : 10'h0FA + 10'h032 * sink_current_code))
    else $error("flash current decode wrong");
  AST_REG_A: assert property ($stable(regulator_a_voltage) [*3] |->
    reg_a_mv == ((regulator_a_voltage == 4'h0 || regulator_a_voltage >
    4'h9) ? 12'h000 : 12'hD48 - 12'h064 * regulator_a_voltage))
    else $error("regulator A decode wrong");
  AST_REG_B: assert property ($stable(regulator_b_voltage) [*3] |->
    reg_b_mv == ((regulator_b_voltage == 3'h0 || regulator_b_voltage >
    3'h4) ? 12'h000 : 12'h76C - 12'h064 * regulator_b_voltage))
    else $error("regulator B decode wrong");
  AST_TIMED: assert property (timed_out |-> !sink_on)
    else $error("sink on after timeout");
endmodule : swf_asserts

// file: bench/single_wire_flash_ldo_ctrl_tb_top.sv
// Testbench joining host and device ends over one wire.
`timescale 1ns/1ps
module single_wire_flash_ldo_ctrl_tb_top;
  localparam int BIT = 20;
  localparam int EN = 200;
  localparam int DIS = 2000;
  localparam int TOC = 500;
  logic pclk, presetn, psel, penable, pwrite, strobe_enable_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic pready, pslverr, e, enabled, awake, range_select, sink_on;
  logic flash_timeout_enable, timed_out;
  logic [2:0] sink_current_code, regulator_b_voltage;
  logic [3:0] regulator_a_voltage;
  logic [9:0] sink_ma;
  logic [11:0] reg_a_mv, reg_b_mv, cfg, cfg_last;
  logic [11:0] notes[$];
  logic [7:0] cur_f, cur_r, d;
  int n_mismatch, comparisons, seed;

  swf_link_if link();
  swf_host #(.EN_CYC(EN)) swf_host_i (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .link(link));
  swf_device #(.EN_CYC(EN), .DIS_CYC(DIS), .TIMEOUT_CYC(TOC)) swf_device_i (
    .pclk, .presetn, .link(link), .strobe_enable_pin, .enabled, .awake,
    .range_select, .flash_timeout_enable, .sink_current_code, .sink_on,
    .timed_out, .sink_ma, .regulator_a_voltage, .regulator_b_voltage,
    .reg_a_mv, .reg_b_mv);
  swf_asserts #(.EN_CYC(EN), .DIS_CYC(DIS), .QUIET(24 * BIT)) chk_i (
    .pclk, .presetn, .line(link.line), .enabled, .awake, .range_select,
    .flash_timeout_enable, .sink_current_code, .sink_on, .timed_out,
    .sink_ma, .regulator_a_voltage, .regulator_b_voltage, .reg_a_mv,
    .reg_b_mv);

  assign cfg = {range_select, flash_timeout_enable, sink_current_code,
                regulator_a_voltage, regulator_b_voltage};

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, x, g);
    end
  endtask : chk

  task automatic chk_cfg(input logic [11:0] x, input logic [11:0] g);
    comparisons++;
    if (g !== x) begin
      n_mismatch++;
      $display("MISMATCH config exp %h got %h", x, g);
    end
  endtask : chk_cfg

  // Each change of the device settings consumes the oldest note.
  always @(posedge pclk) begin
    if (presetn && cfg !== cfg_last) begin
      cfg_last <= cfg;
      chk_cfg(notes.size() > 0 ? notes.pop_front() : cfg_last, cfg);
    end
  end

  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] wd);
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic power(input logic p);
    apb(swf_pkg::CTRL_OFS, 1'b1, {16'(BIT), 15'h0000, p});
  endtask : power

  task automatic idle;
    for (int i = 0; i < 400; i++) begin
      apb(swf_pkg::STATUS_OFS, 1'b0, 32'h0);
      if (r[0] === 1'b0 && r[2] === 1'b0) break;
    end
    repeat (4) @(posedge pclk);
  endtask : idle

  task automatic frame(input logic [4:0] a, input logic [7:0] dv,
                       input logic ok, input logic keep);
    apb(swf_pkg::FRAME_OFS, 1'b1, {19'h0, a, dv});
    chk("frame refused", {31'h0, !ok}, {31'h0, e});
    if (ok && keep && (a == 5'h02 || a == 5'h03)) begin
      if (a == 5'h02) cur_f = dv;
      else cur_r = dv;
      notes.push_back({cur_f[0], cur_f[4], cur_f[3:1], cur_r[3:0],
                       cur_r[6:4]});
    end
  endtask : frame

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial begin
    repeat (60000) @(posedge pclk);
    n_mismatch++;
    $display("watchdog expired");
    print_verdict();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    strobe_enable_pin = 1'b1;
    cfg_last = 12'h000;
    cur_f = 8'h10;
    cur_r = 8'h00;
    seed = 27;
    // Outputs leave reset at zero and show the defaults one edge later.
    notes.push_back(12'h400);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(swf_pkg::CTRL_OFS, 1'b0, 32'h0);
    chk("ctrl reset", 32'h0064_0000, r);
    apb(12'hFFC, 1'b0, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    power(1'b1);
    frame(5'h02, 8'h07, 1'b0, 1'b1);
    repeat (EN + 20) @(posedge pclk);
    chk("enabled", 32'h1, {31'h0, enabled});
    chk("asleep", 32'h0, {31'h0, awake});
    $display("test power-up done");
    for (int c = 15; c >= 0; c--) begin
      frame(5'h03, {1'b0, 3'(c), 4'(c)}, 1'b1, 1'b1);
      idle();
    end
    $display("test regulator codes done");
    for (int i = 0; i < 8; i++) begin
      d = {3'h0, 5'($random(seed))};
      if (d == cur_f) d = d ^ 8'h01;
      frame(5'h02, d, 1'b1, 1'b1);
      idle();
    end
    frame(5'h1F, 8'h15, 1'b1, 1'b1);
    frame(5'h02, cur_f ^ 8'h0E, 1'b1, 1'b1);
    frame(5'h03, 8'h00, 1'b0, 1'b1);
    idle();
    $display("test flash codes and chaining done");
    // A value equal to the current one would leave its note unconsumed.
    frame(5'h02, (cur_f == 8'h17) ? 8'h16 : 8'h17, 1'b1, 1'b1);
    idle();
    repeat (TOC + 50) @(posedge pclk);
    chk("timed out", 32'h1, {31'h0, timed_out});
    chk("sink off", 32'h0, {31'h0, sink_on});
    strobe_enable_pin <= 1'b0;
    repeat (5) @(posedge pclk);
    strobe_enable_pin <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("rearmed", 32'h1, {31'h0, sink_on});
    frame(5'h02, 8'h01, 1'b1, 1'b1);
    idle();
    repeat (30 * BIT) @(posedge pclk);
    chk("asleep", 32'h0, {31'h0, awake});
    $display("test timeout done");
    frame(5'h03, 8'h55, 1'b1, 1'b0);
    repeat (5 * BIT) @(posedge pclk);
    power(1'b0);
    cur_f = 8'h10;
    cur_r = 8'h00;
    notes.push_back(12'h400);
    repeat (DIS + 50) @(posedge pclk);
    chk("shut down", 32'h0, {31'h0, enabled});
    power(1'b1);
    repeat (EN + 20) @(posedge pclk);
    frame(5'h03, 8'h21, 1'b1, 1'b1);
    idle();
    $display("test shutdown done");
    print_verdict();
  end
endmodule : single_wire_flash_ldo_ctrl_tb_top
